// >>> hdl/usb_cond_pkg.sv
package usb_cond_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_KHZ          = 125000;  // sys_clk rate
  localparam int SD_PW_US         = 20;      // least valid shutdown pulse
  localparam int SD_PW_CYC        = (SD_PW_US * CLK_KHZ + 999) / 1000;
  localparam int SUPPLY_STABLE_US = 100;     // supply settle before release
  localparam int SAMPLE_NS        = 1000;    // delay from release to strap sample
  localparam int SAMPLE_CYC       = (SAMPLE_NS * CLK_KHZ) / 1000000;
  localparam int CNT_W            = 12;      // phase counter width

  // ----------------------------------------------------------------
  // serial target
  // ----------------------------------------------------------------
  localparam logic [6:0] TARGET_ADDR = 7'h2c;
  localparam logic [3:0] BYTE_BITS   = 4'h8;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_RESERVED   = 8'h00;
  localparam logic [7:0] OFS_CTRL       = 8'h01;
  localparam logic [7:0] OFS_ID         = 8'h02;
  localparam logic [7:0] RESERVED_RST   = 8'h00;
  localparam logic [7:0] CTRL_RST       = 8'h00;
  localparam int         CTRL_SENS_LSB  = 0;
  localparam int         CTRL_BOOST_LSB = 2;
  localparam logic [1:0] CTRL_TOP_RST   = 2'h0;  // bits 7:6 after strap load

  // ----------------------------------------------------------------
  // strap codes
  // ----------------------------------------------------------------
  localparam logic [3:0] BOOST_SET0  = 4'h0;
  localparam logic [3:0] BOOST_SET1  = 4'h5;
  localparam logic [3:0] BOOST_SET2  = 4'ha;
  localparam logic [3:0] BOOST_SET3  = 4'hf;
  localparam logic [1:0] SENS_SUPPLY = 2'h3;
  localparam logic [1:0] SENS_FLOAT  = 2'h2;
  localparam logic [1:0] SENS_GROUND = 2'h1;

  typedef enum logic [1:0] {PH_OFF, PH_WAIT, PH_RUN} phase_type;
  typedef enum logic [2:0] {
    I_IDLE, I_ADDR, I_ACK_A, I_WR, I_ACK_W, I_RD, I_RACK
  } i2c_state_type;

  // boost strap setting to level code
  function automatic logic [3:0] boost_code(input logic [1:0] sel);
    case (sel)
      2'h0:    boost_code = BOOST_SET0;
      2'h1:    boost_code = BOOST_SET1;
      2'h2:    boost_code = BOOST_SET2;
      default: boost_code = BOOST_SET3;
    endcase
  endfunction

endpackage

// >>> hdl/pin_sync.sv
`timescale 1ns/100ps
module pin_sync
  import usb_cond_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         sys_clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level_out
);

  // ----------------------------------------------------------------
  // three stages, value taken once stages two and three agree
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [W-1:0] s1;  // metastable stage
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;   // agreed level
  } sync_type;

  sync_type r;
  sync_type n;

  if (W < 1) begin : g_bad_width
    $error("pin_sync width must be at least one");
  end

  // next stage values, s1 read only by s2
  always_comb begin
    n    = r;
    n.s1 = pin_in;
    n.s2 = r.s1;
    n.s3 = r.s2;
    n.q  = (r.s2 & r.s3) | (r.q & (r.s2 | r.s3));
  end

  // register the copy
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign level_out = r.q;

endmodule

// >>> hdl/i2c_target.sv
`timescale 1ns/100ps
module i2c_target
  import usb_cond_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  input  wire logic       enable,
  input  wire logic       scl_lvl,
  input  wire logic       sda_lvl,
  input  wire logic [7:0] rd_data,
  output logic      [7:0] reg_ptr,
  output logic            wr_stb,
  output logic      [7:0] wr_data,
  output logic            sda_oe
);

  typedef struct packed {
    i2c_state_type st;
    logic          scl_p;  // previous line levels
    logic          sda_p;
    logic [7:0]    sh;     // shift register
    logic [3:0]    cnt;    // bits this byte
    logic          rw;     // read direction
    logic          first;  // next byte is pointer
    logic          nack;   // host refused more data
    logic          drv;    // pull sda low
    logic [7:0]    ptr;
    logic          wstb;
    logic [7:0]    wdat;
  } tgt_type;

  tgt_type r;
  tgt_type n;
  logic    rise;
  logic    fall;
  logic    start;
  logic    stop;

  // ----------------------------------------------------------------
  // bus events
  // ----------------------------------------------------------------
  assign rise  = scl_lvl & !r.scl_p;
  assign fall  = !scl_lvl & r.scl_p;
  assign start = scl_lvl & r.scl_p & r.sda_p & !sda_lvl;
  assign stop  = scl_lvl & r.scl_p & !r.sda_p & sda_lvl;

  // byte engine: address, pointer, data with auto increment
  always_comb begin
    n       = r;
    n.scl_p = scl_lvl;
    n.sda_p = sda_lvl;
    n.wstb  = 1'b0;
    if (!enable) begin
      n.st  = I_IDLE;
      n.drv = 1'b0;
    end else if (start) begin
      n.st  = I_ADDR;
      n.cnt = 4'h0;
      n.drv = 1'b0;
    end else if (stop) begin
      n.st  = I_IDLE;
      n.drv = 1'b0;
    end else if (rise) begin
      case (r.st)
        I_ADDR, I_WR: begin
          n.sh  = {r.sh[6:0], sda_lvl};
          n.cnt = r.cnt + 4'h1;
        end
        I_RD: begin
          n.sh  = {r.sh[6:0], 1'b0};
          n.cnt = r.cnt + 4'h1;
        end
        I_RACK:  n.nack = sda_lvl;
        default: n.nack = r.nack;
      endcase
    end else if (fall) begin
      case (r.st)
        I_ADDR: begin
          if (r.cnt == BYTE_BITS) begin
            if (r.sh[7:1] == TARGET_ADDR) begin
              n.st  = I_ACK_A;
              n.drv = 1'b1;
              n.rw  = r.sh[0];
            end else begin
              n.st = I_IDLE;
            end
          end
        end
        I_ACK_A: begin
          n.cnt   = 4'h0;
          n.first = 1'b1;
          if (r.rw) begin
            n.st  = I_RD;
            n.sh  = rd_data;
            n.drv = !rd_data[7];
          end else begin
            n.st  = I_WR;
            n.drv = 1'b0;
          end
        end
        I_WR: begin
          if (r.cnt == BYTE_BITS) begin
            n.st  = I_ACK_W;
            n.drv = 1'b1;
            if (r.first) begin
              n.ptr = r.sh;
            end else begin
              n.wstb = 1'b1;
              n.wdat = r.sh;
            end
          end
        end
        I_ACK_W: begin
          n.st    = I_WR;
          n.cnt   = 4'h0;
          n.drv   = 1'b0;
          n.first = 1'b0;
          if (!r.first) begin
            n.ptr = r.ptr + 8'h01;
          end
        end
        I_RD: begin
          if (r.cnt == BYTE_BITS) begin
            n.st  = I_RACK;
            n.drv = 1'b0;
            n.ptr = r.ptr + 8'h01;
          end else begin
            n.drv = !r.sh[7];
          end
        end
        I_RACK: begin
          if (r.nack) begin
            n.st = I_IDLE;
          end else begin
            n.st  = I_RD;
            n.cnt = 4'h0;
            n.sh  = rd_data;
            n.drv = !rd_data[7];
          end
        end
        default: n.st = I_IDLE;
      endcase
    end
  end

  // register the copy
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      r <= '{st: I_IDLE, scl_p: 1'b1, sda_p: 1'b1, default: '0};
    end else begin
      r <= n;
    end
  end

  assign reg_ptr = r.ptr;
  assign wr_stb  = r.wstb;
  assign wr_data = r.wdat;
  assign sda_oe  = r.drv;

  // foreign address never acknowledged
  chk_addr_nomatch: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    (enable && !start && !stop && fall && r.st == I_ADDR
      && r.cnt == BYTE_BITS && r.sh[7:1] != TARGET_ADDR) |=> !sda_oe
  ) else $error("ack driven for foreign address");

endmodule

// >>> hdl/usb_conditioner_config.sv
`timescale 1ns/100ps
module usb_conditioner_config
  import usb_cond_pkg::*;
#(
  parameter logic [7:0] PART_ID = 8'h5a  // arbitrary value
) (
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  input  wire logic       shutdown_n,
  input  wire logic [1:0] boost_strap_sel,
  input  wire logic       sens_at_supply,
  input  wire logic       sens_at_ground,
  input  wire logic       det_ls_fs,
  input  wire logic       det_hs,
  input  wire logic       det_otg_bc,
  input  wire logic       charge_port_enable_n,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  output logic            connect_detect_out,
  output logic            connect_detect_oe,
  output logic            high_speed_detect_out,
  output logic            sensitivity_strap_pin_oe,
  output logic            comp_enable,
  output logic      [3:0] boost_level,
  output logic      [1:0] sens_level,
  output logic            charging_downstream_port_function,
  output logic            i2c_mode_active
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    phase_type        ph;         // shutdown, settle, running
    logic [CNT_W-1:0] cnt;        // settle or low-width count
    logic [1:0]       boost_sel;  // latched boost strap
    logic [1:0]       sens_code;  // latched sensitivity code
    logic             i2c_mode;   // register mode picked
    logic [7:0]       rsv;        // reserved register
    logic [7:0]       ctrl;       // control register
    logic             conn;       // pin outputs, registered
    logic             conn_oe;
    logic             hs;
    logic             spd_oe;
    logic             comp;
    logic [3:0]       boost;
    logic [1:0]       sens;
    logic             chg;
  } cfg_type;

  cfg_type    r;
  cfg_type    n;

  logic [8:0] pins_lvl;   // synchronised straps and detects
  logic [1:0] i2c_lvl;    // synchronised scl, sda
  logic       sd_lvl;     // shutdown line, high = run
  logic [1:0] bsel_lvl;   // boost strap setting
  logic [1:0] sens_dec;   // sensitivity strap decoded
  logic       lsfs_lvl;
  logic       hs_lvl;
  logic       otg_lvl;
  logic       chg_lvl;    // charge function requested
  logic       mode_smp;   // both serial lines high
  logic       run;
  logic       hs_con;     // high speed, not otg
  logic       fs_con;     // low/full speed, not otg
  logic [7:0] ptr;
  logic       wr_stb;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  logic       tgt_drv;

  if (SD_PW_CYC >= (1 << CNT_W) || SAMPLE_CYC < 1) begin : g_bad_count
    $error("phase counter too narrow for timing counts");
  end

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  pin_sync #(
    .W (9)
  ) u_pins (
    .sys_clk   (sys_clk),
    .nrst      (nrst),
    .pin_in    ({shutdown_n, boost_strap_sel, sens_at_supply,
                 sens_at_ground, det_ls_fs, det_hs, det_otg_bc,
                 !charge_port_enable_n}),
    .level_out (pins_lvl)
  );

  pin_sync #(
    .W (2)
  ) u_i2c_pins (
    .sys_clk   (sys_clk),
    .nrst      (nrst),
    .pin_in    ({scl_in, sda_in}),
    .level_out (i2c_lvl)
  );

  assign sd_lvl   = pins_lvl[8];
  assign bsel_lvl = pins_lvl[7:6];
  assign lsfs_lvl = pins_lvl[3];
  assign hs_lvl   = pins_lvl[2];
  assign otg_lvl  = pins_lvl[1];
  assign chg_lvl  = pins_lvl[0];
  assign mode_smp = i2c_lvl[1] & i2c_lvl[0];

  // three level sensitivity strap
  always_comb begin
    if (pins_lvl[5]) begin
      sens_dec = SENS_SUPPLY;
    end else if (pins_lvl[4]) begin
      sens_dec = SENS_GROUND;
    end else begin
      sens_dec = SENS_FLOAT;
    end
  end

  // ----------------------------------------------------------------
  // serial target
  // ----------------------------------------------------------------
  i2c_target u_tgt (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .enable  (r.ph == PH_RUN && r.i2c_mode),
    .scl_lvl (i2c_lvl[1]),
    .sda_lvl (i2c_lvl[0]),
    .rd_data (rd_data),
    .reg_ptr (ptr),
    .wr_stb  (wr_stb),
    .wr_data (wr_data),
    .sda_oe  (tgt_drv)
  );

  // register read mux, unmapped reads as zero
  always_comb begin
    case (ptr)
      OFS_RESERVED: rd_data = r.rsv;
      OFS_CTRL:     rd_data = r.ctrl;
      OFS_ID:       rd_data = PART_ID;
      default:      rd_data = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // phase, registers and pin outputs
  // ----------------------------------------------------------------
  assign run    = (r.ph == PH_RUN);
  assign hs_con = hs_lvl & !otg_lvl;
  assign fs_con = lsfs_lvl & !hs_lvl & !otg_lvl;

  always_comb begin
    n = r;
    case (r.ph)
      // held in shutdown until the line is released
      PH_OFF: begin
        n.cnt = '0;
        if (sd_lvl) begin
          n.ph = PH_WAIT;
        end
      end
      // short settle, then strap sampling
      PH_WAIT: begin
        if (!sd_lvl) begin
          n.ph  = PH_OFF;
          n.cnt = '0;
        end else if (r.cnt == CNT_W'(SAMPLE_CYC - 1)) begin
          n.ph        = PH_RUN;
          n.cnt       = '0;
          n.boost_sel = bsel_lvl;
          n.sens_code = sens_dec;
          n.i2c_mode  = mode_smp;
          n.ctrl      = {CTRL_TOP_RST, boost_code(bsel_lvl),
                         sens_dec};
        end else begin
          n.cnt = r.cnt + CNT_W'(1);
        end
      end
      // a low must last the full width to count
      PH_RUN: begin
        if (sd_lvl) begin
          n.cnt = '0;
        end else if (r.cnt == CNT_W'(SD_PW_CYC - 1)) begin
          n.ph  = PH_OFF;
          n.cnt = '0;
        end else begin
          n.cnt = r.cnt + CNT_W'(1);
        end
      end
      default: n.ph = PH_OFF;
    endcase

    // register writes only in register mode
    if (run && r.i2c_mode && wr_stb) begin
      case (ptr)
        OFS_RESERVED: n.rsv  = wr_data;
        OFS_CTRL:     n.ctrl = wr_data;
        default:      n.rsv  = r.rsv;
      endcase
    end

    // connection indications and compensation
    n.comp   = run & hs_con;
    n.conn    = run & !r.i2c_mode & (hs_con | fs_con);
    n.conn_oe = run & !r.i2c_mode;
    n.hs      = run & !r.i2c_mode & hs_con;
    n.spd_oe  = run;

    // levels: straps in pin mode, control register otherwise
    if (r.i2c_mode) begin
      n.boost = r.ctrl[CTRL_BOOST_LSB+:4];
      n.sens  = r.ctrl[CTRL_SENS_LSB+:2];
    end else begin
      n.boost = boost_code(r.boost_sel);
      n.sens  = r.sens_code;
    end
    n.chg = chg_lvl;
  end

  // register the copy
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      r <= '{ph: PH_OFF, rsv: RESERVED_RST, ctrl: CTRL_RST, default: '0};
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign sda_out                           = 1'b0;
  assign sda_oe                            = tgt_drv;
  assign connect_detect_out                = r.conn;
  assign connect_detect_oe                 = r.conn_oe;
  assign high_speed_detect_out             = r.hs;
  assign sensitivity_strap_pin_oe          = r.spd_oe;
  assign comp_enable                       = r.comp;
  assign boost_level                       = r.boost;
  assign sens_level                        = r.sens;
  assign charging_downstream_port_function = r.chg;
  assign i2c_mode_active                   = r.i2c_mode & run;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] low_cnt;  // consecutive low samples

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      low_cnt <= '0;
    end else if (sd_lvl) begin
      low_cnt <= '0;
    end else if (low_cnt != '1) begin
      low_cnt <= low_cnt + CNT_W'(1);
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  chk_shutdown_width: assert property (
    ($past(r.ph) == PH_RUN && r.ph == PH_OFF) |-> low_cnt >= CNT_W'(SD_PW_CYC)
  ) else $error("shutdown taken on a short pulse");

  chk_shutdown_ignore: assert property (
    (r.ph == PH_RUN && sd_lvl) |=> r.ph == PH_RUN
  ) else $error("left run while line high");

  chk_boost_load: assert property (
    ($past(r.ph) == PH_WAIT && r.ph == PH_RUN)
      |-> r.ctrl[CTRL_BOOST_LSB+:4] == boost_code($past(bsel_lvl))
  ) else $error("boost default not loaded from strap");

  chk_sens_load: assert property (
    ($past(r.ph) == PH_WAIT && r.ph == PH_RUN)
      |-> r.sens_code == $past(sens_dec) && r.ctrl[1:0] == $past(sens_dec)
  ) else $error("sensitivity default not loaded");

  chk_pin_levels: assert property (
    (run && !r.i2c_mode) ##1 run
      |-> boost_level == boost_code(r.boost_sel) && sens_level == r.sens_code
  ) else $error("pin mode levels differ from straps");

  chk_hs_pin_dir: assert property (
    run ##1 run |-> sensitivity_strap_pin_oe
  ) else $error("sensitivity pin not an output in run");

  chk_charge_follow: assert property (
    $stable(charge_port_enable_n) [*6]
      |-> charging_downstream_port_function == !charge_port_enable_n
  ) else $error("charging port does not follow enable");

  chk_mode_pick: assert property (
    ($past(r.ph) == PH_WAIT && r.ph == PH_RUN) |-> r.i2c_mode == $past(mode_smp)
  ) else $error("mode not picked from serial lines");

  chk_lsfs_cd: assert property (
    (run && !r.i2c_mode && fs_con) |=> connect_detect_out && !comp_enable
  ) else $error("low/full speed indication wrong");

  chk_hs_comp: assert property (
    (run && hs_con) |=> comp_enable
      && ($past(r.i2c_mode) || (connect_detect_out && high_speed_detect_out))
  ) else $error("high speed indication wrong");

  chk_otg_off: assert property (
    (run && otg_lvl) |=> !comp_enable && !connect_detect_out
  ) else $error("otg signalling compensated");

  chk_shutdown_quiet: assert property (
    (r.ph != PH_RUN) |=> !comp_enable && !connect_detect_oe
      && !sensitivity_strap_pin_oe && !connect_detect_out && !high_speed_detect_out
  ) else $error("activity during shutdown");

  chk_ctrl_write: assert property (
    (run && r.i2c_mode && wr_stb && ptr == OFS_CTRL)
      |=> r.ctrl == $past(wr_data) ##1 boost_level == $past(wr_data[5:2], 2)
  ) else $error("control write not applied");

endmodule

// >>> testbench/serial_host_model.sv
`timescale 1ns/100ps
module serial_host_model (
  input  wire logic sys_clk,
  input  wire logic dev_sda_oe,
  output logic      scl_low,
  output logic      sda_lvl
);
  // ----------------------------------------------------------------
  // open drain host, both lines pulled up when released
  // ----------------------------------------------------------------
  logic sda_low;  // host pulls data low
  assign sda_lvl = !(sda_low | dev_sda_oe);  // wired and
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // quarter bit, 128 cycles a bit keeps the rate under 1 mhz
  task automatic q;
    repeat (32) @(negedge sys_clk);
  endtask
  // strap level of the clock line before release
  task automatic hold_scl(input logic v);
    scl_low = v;
  endtask
  // start or repeated start, data falls while clock high
  task automatic start;
    sda_low = 1'b0;
    q;
    scl_low = 1'b0;
    q;
    sda_low = 1'b1;
    q;
    scl_low = 1'b1;
    q;
  endtask
  // stop, data rises while clock high
  task automatic stop;
    sda_low = 1'b1;
    q;
    scl_low = 1'b0;
    q;
    sda_low = 1'b0;
    q;
  endtask
  // one bit, data set in clock low, sampled mid high
  task automatic bit1(input logic b, output logic r);
    sda_low = !b;
    q;
    scl_low = 1'b0;
    q;
    r = sda_lvl;
    q;
    scl_low = 1'b1;
    q;
  endtask
  // byte msb first plus ninth bit
  task automatic xfer(input logic [7:0] d, input logic b9, output logic [7:0] r,
                      output logic r9);
    for (int i = 7; i >= 0; i--) begin
      bit1(d[i], r[i]);
    end
    bit1(b9, r9);
  endtask
  task automatic wr(input logic [7:0] d, output logic ack);
    logic [7:0] r;
    logic       a;
    xfer(d, 1'b1, r, a);
    ack = !a;
  endtask
  // read a byte, last one answered with no ack
  task automatic rd(input logic last, output logic [7:0] d);
    logic a;
    xfer(8'hff, last, d, a);
  endtask
endmodule

// >>> testbench/usb_conditioner_config_tb.sv
`timescale 1ns/100ps
module usb_conditioner_config_tb;
  import usb_cond_pkg::*;
  localparam logic [7:0] ID_VAL = 8'h3c;  // arbitrary value
  logic       sys_clk, nrst, shutdown_n, sup, gnd, lsfs, hs, otg, cpe_n;
  logic       scl_low, scl_lvl, sda_lvl, sda_oe, conn, conn_oe, hs_out, spd_oe;
  logic       comp, chg, i2c_on, a, sda_o;
  logic [1:0] bsel, sens;
  logic [3:0] boost;
  logic [7:0] d;
  int         n_mismatch, total_checks;
  // clock line is the connect output in pin mode
  assign scl_lvl = conn_oe ? conn : !scl_low;
  usb_conditioner_config #(.PART_ID(ID_VAL)) u_dut (
    .sys_clk(sys_clk), .nrst(nrst), .shutdown_n(shutdown_n), .boost_strap_sel(bsel),
    .sens_at_supply(sup), .sens_at_ground(gnd), .det_ls_fs(lsfs), .det_hs(hs),
    .det_otg_bc(otg), .charge_port_enable_n(cpe_n), .scl_in(scl_lvl), .sda_in(sda_lvl),
    .sda_out(sda_o), .sda_oe(sda_oe), .connect_detect_out(conn), .connect_detect_oe(conn_oe),
    .high_speed_detect_out(hs_out), .sensitivity_strap_pin_oe(spd_oe),
    .comp_enable(comp), .boost_level(boost), .sens_level(sens),
    .charging_downstream_port_function(chg), .i2c_mode_active(i2c_on));
  serial_host_model m (.sys_clk(sys_clk), .dev_sda_oe(sda_oe), .scl_low(scl_low),
    .sda_lvl(sda_lvl));
  always #4 sys_clk = ~sys_clk;
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // straps set during shutdown, then release
  task automatic boot(input logic [1:0] b, input logic s, input logic g, input logic md);
    shutdown_n = 1'b0;
    bsel = b;
    sup = s;
    gnd = g;
    m.hold_scl(!md);
    wait_n(2600);
    shutdown_n = 1'b1;  // supply long settled by now
    wait_n(200);
  endtask
  task automatic reg_wr(input logic [7:0] o, input logic [7:0] v);
    m.start;
    m.wr({TARGET_ADDR, 1'b0}, a);
    chk("wr_ack", 8'h01, a);
    m.wr(o, a);
    chk("ptr_ack", 8'h01, a);
    m.wr(v, a);
    chk("data_ack", 8'h01, a);
    m.stop;
  endtask
  task automatic reg_rd(input logic [7:0] o);
    m.start;
    m.wr({TARGET_ADDR, 1'b0}, a);
    m.wr(o, a);
    m.start;
    m.wr({TARGET_ADDR, 1'b1}, a);
    chk("rd_ack", 8'h01, a);
    m.rd(1'b1, d);
    m.stop;
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    {sys_clk, nrst, shutdown_n, sup, gnd, lsfs, hs, otg, bsel} = '0;
    cpe_n = 1'b1;
    wait_n(20);
    nrst = 1'b1;
    wait_n(SUPPLY_STABLE_US * CLK_KHZ / 1000);
    boot(2'h2, 1'b0, 1'b0, 1'b0);
    chk("boost", 8'h0a, boost);
    chk("sens", 8'h02, sens);
    chk("spd_oe", 8'h01, spd_oe);
    chk("i2c_on", 8'h00, i2c_on);
    chk("conn_oe_pin", 8'h01, conn_oe);
    chk("sda_out", 8'h00, sda_o);
    // every detect combination, otg wins
    for (int i = 0; i < 8; i++) begin
      {otg, hs, lsfs} = i[2:0];
      wait_n(10);
      chk("comp", hs & !otg, comp);
      chk("conn", (hs | lsfs) & !otg, conn);
      chk("hs", hs & !otg, hs_out);
    end
    for (int i = 0; i < 2; i++) begin
      cpe_n = i[0];
      wait_n(10);
      chk("chg", !cpe_n, chg);
    end
    $display("test pin_mode done");
    {otg, hs, lsfs} = 3'h2;
    cpe_n = 1'b0;
    shutdown_n = 1'b0;
    wait_n(2400);
    shutdown_n = 1'b1;
    wait_n(10);
    chk("comp_short", 8'h01, comp);
    shutdown_n = 1'b0;
    wait_n(2600);
    chk("comp_sd", 8'h00, comp);
    chk("conn_sd", 8'h00, conn);
    chk("hs_sd", 8'h00, hs_out);
    chk("chg_sd", 8'h01, chg);
    $display("test shutdown done");
    boot(2'h3, 1'b1, 1'b0, 1'b1);
    chk("i2c_on", 8'h01, i2c_on);
    chk("conn_oe", 8'h00, conn_oe);
    chk("comp_reg", 8'h01, comp);
    reg_rd(OFS_CTRL);
    chk("ctrl_rst", 8'h3f, d);
    reg_rd(OFS_RESERVED);
    chk("resv_rst", 8'h00, d);
    reg_wr(OFS_ID, 8'h00);
    reg_rd(OFS_ID);
    chk("id", ID_VAL, d);
    reg_wr(OFS_CTRL, 8'hc6);
    chk("boost_wr", 8'h01, boost);
    chk("sens_wr", 8'h02, sens);
    reg_rd(OFS_CTRL);
    chk("ctrl_rd", 8'hc6, d);
    m.start;
    m.wr(8'h5a, a);
    m.stop;
    chk("foreign_ack", 8'h00, a);
    $display("test register_mode done");
    // lowest boost settings and a grounded sensitivity strap, pin mode
    for (int i = 0; i < 2; i++) begin
      boot(i[1:0], 1'b0, 1'b1, 1'b0);
      chk("boost_low", i ? 8'h05 : 8'h00, boost);
      chk("sens_gnd", 8'h01, sens);
      chk("i2c_off", 8'h00, i2c_on);
    end
    $display("test strap_low done");
    give_verdict;
  end
  // watchdog, tests need about two thirds of this span
  initial begin
    wait_n(90000);
    n_mismatch++;
    give_verdict;
  end
endmodule
